// ==== rtl/srse_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module srse_exec (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // Instruction issue
  input wire logic START_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic [7:0] OPERAND_IN,
  input wire logic [15:0] OPERAND_ADDR_IN,
  // Memory
  input wire logic [7:0] MEM_RDATA_IN,
  output logic [15:0] MEM_ADDR_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  output logic MEM_RD_OUT,
  output logic MEM_WR_OUT,
  // State
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic ILLEGAL_OUT,
  output srse_pkg::srse_regs_s REGS_OUT
);
  // ==========================================================
  // Decode
  typedef enum {SRSE_IDLE, SRSE_RUN} srse_state_e;
  srse_state_e state;
  srse_pkg::srse_regs_s r;
  logic [7:0] op;
  logic [3:0] cnt;
  logic [2:0] pulls;
  // Read data arrives a cycle after the strobe, so landings trail issues
  logic land;
  logic [2:0] land_cnt;
  logic [3:0] next_cycles;
  logic next_legal;

  always_comb begin
    next_legal = 1'b1;
    case (OPCODE_IN)
      srse_pkg::OP_PUSH_A, srse_pkg::OP_PUSH_B,
      srse_pkg::OP_PULL_A, srse_pkg::OP_PULL_B:
        next_cycles = srse_pkg::CYC_STACK;
      srse_pkg::OP_ROL_A, srse_pkg::OP_ROL_B,
      srse_pkg::OP_ROR_A, srse_pkg::OP_ROR_B:
        next_cycles = srse_pkg::CYC_ROT_ACC;
      srse_pkg::OP_ROL_FULL, srse_pkg::OP_ROR_FULL:
        next_cycles = srse_pkg::CYC_ROT_FULL;
      srse_pkg::OP_ROL_OFS, srse_pkg::OP_ROR_OFS:
        next_cycles = srse_pkg::CYC_ROT_OFS;
      srse_pkg::OP_IRET: next_cycles = srse_pkg::CYC_IRET;
      srse_pkg::OP_SRET: next_cycles = srse_pkg::CYC_SRET;
      srse_pkg::OP_ADIFF: next_cycles = srse_pkg::CYC_ADIFF;
      srse_pkg::OP_BSUB_IMM: next_cycles = srse_pkg::CYC_BSUB_IMM;
      srse_pkg::OP_BSUB_DIR: next_cycles = srse_pkg::CYC_BSUB_DIR;
      srse_pkg::OP_BSUB_FULL: next_cycles = srse_pkg::CYC_BSUB_FULL;
      default: begin
        next_cycles = 4'h1;
        next_legal = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Arithmetic, all on the final cycle
  logic is_mem_op;
  logic [7:0] src;
  logic [7:0] sub_b;
  logic [7:0] res;
  logic [7:0] next_flags;
  logic sub_c;
  logic rot_c;
  logic is_rot;
  logic is_sub;
  logic use_b_acc;

  always_comb begin
    use_b_acc = (op == srse_pkg::OP_ROL_B) || (op == srse_pkg::OP_ROR_B);
    is_mem_op = (op == srse_pkg::OP_ROL_FULL) || (op == srse_pkg::OP_ROL_OFS) ||
                (op == srse_pkg::OP_ROR_FULL) || (op == srse_pkg::OP_ROR_OFS);
    src = is_mem_op ? OPERAND_IN :
          (use_b_acc ? r.second_accumulator : r.first_accumulator);
    is_rot = 1'b1;
    is_sub = 1'b0;
    sub_b = (op == srse_pkg::OP_ADIFF) ? r.second_accumulator : OPERAND_IN;
    sub_c = 1'b0;
    rot_c = 1'b0;
    res = src;
    case (op)
      srse_pkg::OP_ROL_A, srse_pkg::OP_ROL_B, srse_pkg::OP_ROL_FULL,
      srse_pkg::OP_ROL_OFS: begin
        res = {src[6:0], r.flag_register[srse_pkg::FLG_C]};
        rot_c = src[7];
      end
      srse_pkg::OP_ROR_A, srse_pkg::OP_ROR_B, srse_pkg::OP_ROR_FULL,
      srse_pkg::OP_ROR_OFS: begin
        res = {r.flag_register[srse_pkg::FLG_C], src[7:1]};
        rot_c = src[0];
      end
      srse_pkg::OP_ADIFF: begin
        is_rot = 1'b0;
        is_sub = 1'b1;
        res = r.first_accumulator - sub_b;
      end
      srse_pkg::OP_BSUB_IMM, srse_pkg::OP_BSUB_DIR,
      srse_pkg::OP_BSUB_FULL: begin
        is_rot = 1'b0;
        is_sub = 1'b1;
        res = r.first_accumulator - sub_b -
              {7'h00, r.flag_register[srse_pkg::FLG_C]};
      end
      default: is_rot = 1'b0;
    endcase
    sub_c = (~r.first_accumulator[7] & sub_b[7]) | (sub_b[7] & res[7]) |
            (res[7] & ~r.first_accumulator[7]);
    next_flags = r.flag_register;
    next_flags[srse_pkg::FLG_N] = res[7];
    next_flags[srse_pkg::FLG_Z] = (res == 8'h00);
    if (is_rot) begin
      next_flags[srse_pkg::FLG_C] = rot_c;
      next_flags[srse_pkg::FLG_V] = res[7] ^ rot_c;
    end else begin
      next_flags[srse_pkg::FLG_C] = sub_c;
      next_flags[srse_pkg::FLG_V] =
        (r.first_accumulator[7] & ~sub_b[7] & ~res[7]) |
        (~r.first_accumulator[7] & sub_b[7] & res[7]);
    end
    if (!is_rot && !is_sub) begin
      next_flags = r.flag_register;
    end
  end

  // ==========================================================
  // Sequencer
  wire last = (state == SRSE_RUN) && (cnt == 4'h1);
  wire is_pull = (op == srse_pkg::OP_PULL_A) || (op == srse_pkg::OP_PULL_B);
  wire is_push = (op == srse_pkg::OP_PUSH_A) || (op == srse_pkg::OP_PUSH_B);
  wire is_iret = (op == srse_pkg::OP_IRET);
  wire is_sret = (op == srse_pkg::OP_SRET);
  // Stack bytes are fetched one per cycle; the memory is assumed to
  // answer reads on the cycle after the strobe
  wire pull_issue = (state == SRSE_RUN) && (pulls != 3'h0);
  wire pull_land = (state == SRSE_RUN) && land;

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      state <= SRSE_IDLE;
      op <= 8'h00;
      cnt <= 4'h0;
      pulls <= 3'h0;
      land <= 1'b0;
      land_cnt <= 3'h0;
      ILLEGAL_OUT <= 1'b0;
    end else begin
      land <= MEM_RD_OUT;
      case (state)
        SRSE_IDLE: if (START_IN) begin
          op <= OPCODE_IN;
          cnt <= next_cycles;
          ILLEGAL_OUT <= !next_legal;
          state <= SRSE_RUN;
          if (OPCODE_IN == srse_pkg::OP_IRET) begin
            pulls <= srse_pkg::IRET_BYTES;
            land_cnt <= srse_pkg::IRET_BYTES;
          end else if (OPCODE_IN == srse_pkg::OP_SRET) begin
            pulls <= 3'h2;
            land_cnt <= 3'h2;
          end else if (OPCODE_IN == srse_pkg::OP_PULL_A ||
                       OPCODE_IN == srse_pkg::OP_PULL_B) begin
            pulls <= 3'h1;
            land_cnt <= 3'h1;
          end else begin
            pulls <= 3'h0;
            land_cnt <= 3'h0;
          end
        end
        SRSE_RUN: begin
          cnt <= cnt - 4'h1;
          if (pull_issue) begin
            pulls <= pulls - 3'h1;
          end
          if (pull_land) begin
            land_cnt <= land_cnt - 3'h1;
          end
          if (last) begin
            state <= SRSE_IDLE;
          end
        end
        default: state <= SRSE_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Memory strobes, one access per stacked byte
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      MEM_RD_OUT <= 1'b0;
      MEM_WR_OUT <= 1'b0;
      MEM_ADDR_OUT <= srse_pkg::RST_STACK;
      MEM_WDATA_OUT <= srse_pkg::RST_BYTE;
    end else begin
      MEM_RD_OUT <= pull_issue;
      MEM_WR_OUT <= is_push && (state == SRSE_RUN) &&
                    (cnt == srse_pkg::CYC_STACK);
      if (pull_issue) begin
        MEM_ADDR_OUT <= r.stack_pointer + 16'h0001;
      end else if (is_push && (state == SRSE_RUN) &&
                   (cnt == srse_pkg::CYC_STACK)) begin
        MEM_ADDR_OUT <= r.stack_pointer;
        MEM_WDATA_OUT <= (op == srse_pkg::OP_PUSH_B) ?
                         r.second_accumulator : r.first_accumulator;
      end
    end
  end
  // ==========================================================
  // Architectural registers
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      r <= '{first_accumulator: srse_pkg::RST_BYTE,
             second_accumulator: srse_pkg::RST_BYTE,
             index_high_byte: srse_pkg::RST_BYTE,
             index_low_byte: srse_pkg::RST_BYTE,
             counter_high_byte: srse_pkg::RST_BYTE,
             counter_low_byte: srse_pkg::RST_BYTE,
             stack_pointer: srse_pkg::RST_STACK,
             flag_register: srse_pkg::RST_FLAGS};
    end else begin
      if (pull_issue) begin
        r.stack_pointer <= r.stack_pointer + 16'h0001;
      end
      if (is_push && (state == SRSE_RUN) &&
          (cnt == srse_pkg::CYC_STACK)) begin
        r.stack_pointer <= r.stack_pointer - 16'h0001;
      end
      if (pull_land && is_pull) begin
        if (op == srse_pkg::OP_PULL_B) begin
          r.second_accumulator <= MEM_RDATA_IN;
        end else begin
          r.first_accumulator <= MEM_RDATA_IN;
        end
      end
      if (pull_land && is_sret) begin
        if (land_cnt == 3'h2) begin
          r.counter_high_byte <= MEM_RDATA_IN;
        end else begin
          r.counter_low_byte <= MEM_RDATA_IN;
        end
      end
      if (pull_land && is_iret) begin
        case (land_cnt)
          3'h7: r.flag_register <= {srse_pkg::FLG_TOP_ONES,
                                    MEM_RDATA_IN[5:0]};
          3'h6: r.second_accumulator <= MEM_RDATA_IN;
          3'h5: r.first_accumulator <= MEM_RDATA_IN;
          3'h4: r.index_high_byte <= MEM_RDATA_IN;
          3'h3: r.index_low_byte <= MEM_RDATA_IN;
          3'h2: r.counter_high_byte <= MEM_RDATA_IN;
          default: r.counter_low_byte <= MEM_RDATA_IN;
        endcase
      end
      if (last && (is_rot || is_sub)) begin
        r.flag_register <= {srse_pkg::FLG_TOP_ONES,
                            next_flags[5:0]};
        if (use_b_acc) begin
          r.second_accumulator <= res;
        end else if (!is_mem_op) begin
          r.first_accumulator <= res;
        end
      end
    end
  end

  // ==========================================================
  // Status outputs
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      REGS_OUT <= '0;
    end else begin
      BUSY_OUT <= (state == SRSE_IDLE) ? START_IN : !last;
      DONE_OUT <= last;
      REGS_OUT <= r;
    end
  end

  // ==========================================================
  // Checks
  chk_push_sp: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    MEM_WR_OUT |-> MEM_ADDR_OUT == r.stack_pointer + 16'h0001)
    else $error("push address not prior stack pointer");
  chk_pull_sp: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    MEM_RD_OUT |-> MEM_ADDR_OUT == r.stack_pointer)
    else $error("pull address not incremented pointer");
  chk_flag_top: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    r.flag_register[7:6] == srse_pkg::FLG_TOP_ONES)
    else $error("flag top bits not one");
  chk_rot_v: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    last && is_rot |=> r.flag_register[1] ==
      (r.flag_register[3] ^ r.flag_register[0]))
    else $error("rotate overflow wrong");
  chk_rot_hi: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    last && is_rot |=> $stable(r.flag_register[5:4]))
    else $error("rotate touched H or I");
  chk_diff_b: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    last && op == srse_pkg::OP_ADIFF |=> $stable(r.second_accumulator))
    else $error("difference changed B");
  chk_iret_len: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    state == SRSE_IDLE && START_IN && OPCODE_IN == srse_pkg::OP_IRET
    |=> ##10 DONE_OUT)
    else $error("interrupt return length wrong");
  chk_sret_len: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    state == SRSE_IDLE && START_IN && OPCODE_IN == srse_pkg::OP_SRET
    |=> ##5 DONE_OUT)
    else $error("subroutine return length wrong");
  cov_iret: cover property (@(posedge CLOCK_IN) last && is_iret);
  cov_push: cover property (@(posedge CLOCK_IN) MEM_WR_OUT);
  cov_bsub: cover property (@(posedge CLOCK_IN) last && is_sub && sub_c);
endmodule : srse_exec
`default_nettype wire

// ==== rtl/srse_pkg.sv ====
package srse_pkg;
  // Opcodes
  localparam logic [7:0] OP_PUSH_A = 8'h36;
  localparam logic [7:0] OP_PUSH_B = 8'h37;
  localparam logic [7:0] OP_PULL_A = 8'h32;
  localparam logic [7:0] OP_PULL_B = 8'h33;
  localparam logic [7:0] OP_ROL_A = 8'h49;
  localparam logic [7:0] OP_ROL_B = 8'h59;
  localparam logic [7:0] OP_ROL_FULL = 8'h79;
  localparam logic [7:0] OP_ROL_OFS = 8'h69;
  localparam logic [7:0] OP_ROR_A = 8'h46;
  localparam logic [7:0] OP_ROR_B = 8'h56;
  localparam logic [7:0] OP_ROR_FULL = 8'h76;
  localparam logic [7:0] OP_ROR_OFS = 8'h66;
  localparam logic [7:0] OP_IRET = 8'h3B;
  localparam logic [7:0] OP_SRET = 8'h39;
  localparam logic [7:0] OP_ADIFF = 8'h10;
  localparam logic [7:0] OP_BSUB_IMM = 8'h82;
  localparam logic [7:0] OP_BSUB_DIR = 8'h92;
  localparam logic [7:0] OP_BSUB_FULL = 8'hB2;
  // Cycle counts per instruction
  localparam logic [3:0] CYC_STACK = 4'h4;
  localparam logic [3:0] CYC_ROT_ACC = 4'h2;
  localparam logic [3:0] CYC_ROT_FULL = 4'h6;
  localparam logic [3:0] CYC_ROT_OFS = 4'h7;
  localparam logic [3:0] CYC_IRET = 4'hA;
  localparam logic [3:0] CYC_SRET = 4'h5;
  localparam logic [3:0] CYC_ADIFF = 4'h2;
  localparam logic [3:0] CYC_BSUB_IMM = 4'h2;
  localparam logic [3:0] CYC_BSUB_DIR = 4'h3;
  localparam logic [3:0] CYC_BSUB_FULL = 4'h4;
  // Flag register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_I = 4;
  localparam int FLG_H = 5;
  localparam logic [1:0] FLG_TOP_ONES = 2'h3;
  // Reset values and the interrupt return byte count
  localparam logic [15:0] RST_STACK = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'hC0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] IRET_BYTES = 3'h7;

  typedef struct packed {
    logic [7:0] first_accumulator;
    logic [7:0] second_accumulator;
    logic [7:0] index_high_byte;
    logic [7:0] index_low_byte;
    logic [7:0] counter_high_byte;
    logic [7:0] counter_low_byte;
    logic [15:0] stack_pointer;
    logic [7:0] flag_register;
  } srse_regs_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } srse_mem_s;
endpackage : srse_pkg

// ==== tb/srse_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Byte-wide memory holding the stack
module srse_mem_model (
  // Clock
  input wire logic clock_in,
  // Memory request from the core
  input wire srse_pkg::srse_mem_s bus_in,
  // Read data, one cycle after the strobe
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] rdata = 8'hA5;

  always @(posedge clock_in) begin
    if (bus_in.wr) begin
      mem[bus_in.addr] <= bus_in.wdata;
    end
  end

  // Idle cycles invert the byte so a late sample never sees stale data
  always @(posedge clock_in) begin
    if (bus_in.rd) begin
      rdata <= mem[bus_in.addr];
    end else begin
      rdata <= ~rdata;
    end
  end

  assign rdata_out = rdata;
endmodule : srse_mem_model
`default_nettype wire

// ==== tb/stack_rotate_subtract_exec_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(80'(g), 80'(e))
// ==========================================
// Bench signals
module stack_rotate_subtract_exec_test;
  logic clock, rst_n, start, rd, wr, busy, done, illegal;
  logic [7:0] opcode, operand, rdata, wdata, push_val;
  logic [15:0] opaddr, mem_addr, push_adr;
  srse_pkg::srse_regs_s regs, shadow;
  srse_pkg::srse_mem_s bus;
  int seed, compares, fails, n_rd, n_wr, seen_rd, seen_wr, cyc;
  logic pushed;
  localparam logic [7:0] OPS [18] = '{srse_pkg::OP_PUSH_A,
    srse_pkg::OP_PUSH_B, srse_pkg::OP_PULL_A, srse_pkg::OP_PULL_B,
    srse_pkg::OP_ROL_A, srse_pkg::OP_ROL_B, srse_pkg::OP_ROL_FULL,
    srse_pkg::OP_ROL_OFS, srse_pkg::OP_ROR_A, srse_pkg::OP_ROR_B,
    srse_pkg::OP_ROR_FULL, srse_pkg::OP_ROR_OFS, srse_pkg::OP_IRET,
    srse_pkg::OP_SRET, srse_pkg::OP_ADIFF, srse_pkg::OP_BSUB_IMM,
    srse_pkg::OP_BSUB_DIR, srse_pkg::OP_BSUB_FULL};

  // ==========================================
  // Design and memory
  srse_exec dut_u (.CLOCK_IN(clock), .RST_N_IN(rst_n), .START_IN(start),
    .OPCODE_IN(opcode), .OPERAND_IN(operand), .OPERAND_ADDR_IN(opaddr),
    .MEM_RDATA_IN(rdata), .MEM_ADDR_OUT(mem_addr), .MEM_WDATA_OUT(wdata),
    .MEM_RD_OUT(rd), .MEM_WR_OUT(wr), .BUSY_OUT(busy), .DONE_OUT(done),
    .ILLEGAL_OUT(illegal), .REGS_OUT(regs));
  assign bus = {rd, wr, mem_addr, wdata};
  srse_mem_model mem_u (.clock_in(clock), .bus_in(bus), .rdata_out(rdata));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    if (rd === 1'b1) seen_rd++;
    if (wr === 1'b1) seen_wr++;
  end

  // ==========================================
  // Checking and verdict
  task automatic check_val(input logic [79:0] got, input logic [79:0] want);
    compares++;
    if (got !== want) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check_val

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ==========================================
  // Expected behaviour
  function automatic logic [7:0] pop();
    shadow.stack_pointer = shadow.stack_pointer + 16'h0001;
    n_rd++;
    return mem_u.mem[shadow.stack_pointer];
  endfunction : pop

  task automatic set_nzvc(input logic [7:0] r, input logic v, input logic c);
    shadow.flag_register[3:0] = {r[7], r == 8'h00, v, c};
  endtask : set_nzvc

  task automatic do_sub(input logic [7:0] m, input logic ci);
    logic [7:0] a;
    logic [7:0] r;
    a = shadow.first_accumulator;
    r = a - m - {7'h00, ci};
    shadow.first_accumulator = r;
    set_nzvc(r, a[7] & ~m[7] & ~r[7] | ~a[7] & m[7] & r[7],
      ~a[7] & m[7] | m[7] & r[7] | r[7] & ~a[7]);
  endtask : do_sub

  task automatic predict(input logic [7:0] op, input logic [7:0] opd);
    logic [7:0] x;
    logic [7:0] r;
    logic c;
    c = shadow.flag_register[0];
    n_rd = 0;
    n_wr = 0;
    pushed = 1'b0;
    case (op)
      8'h36, 8'h37: begin
        push_val = op[0] ? shadow.second_accumulator : shadow.first_accumulator;
        push_adr = shadow.stack_pointer;
        shadow.stack_pointer = shadow.stack_pointer - 16'h0001;
        pushed = 1'b1;
        n_wr = 1;
        cyc = 4;
      end
      8'h32: begin shadow.first_accumulator = pop(); cyc = 4; end
      8'h33: begin shadow.second_accumulator = pop(); cyc = 4; end
      8'h3B: begin
        shadow.flag_register = pop() | 8'hC0;
        shadow.second_accumulator = pop();
        shadow.first_accumulator = pop();
        shadow.index_high_byte = pop();
        shadow.index_low_byte = pop();
        shadow.counter_high_byte = pop();
        shadow.counter_low_byte = pop();
        cyc = 10;
      end
      8'h39: begin
        shadow.counter_high_byte = pop();
        shadow.counter_low_byte = pop();
        cyc = 5;
      end
      8'h10: begin do_sub(shadow.second_accumulator, 1'b0); cyc = 2; end
      8'h82: begin do_sub(opd, c); cyc = 2; end
      8'h92: begin do_sub(opd, c); cyc = 3; end
      8'hB2: begin do_sub(opd, c); cyc = 4; end
      default: begin
        x = op[7:4] == 4'h4 ? shadow.first_accumulator :
          op[7:4] == 4'h5 ? shadow.second_accumulator : opd;
        if (op[3:0] == 4'h9) begin
          r = {x[6:0], c};
          c = x[7];
        end else begin
          r = {c, x[7:1]};
          c = x[0];
        end
        set_nzvc(r, r[7] ^ c, c);
        if (op[7:4] == 4'h4) shadow.first_accumulator = r;
        if (op[7:4] == 4'h5) shadow.second_accumulator = r;
        cyc = op[7:4] == 4'h7 ? 6 : op[7:4] == 4'h6 ? 7 : 2;
      end
    endcase
  endtask : predict

  // ==========================================
  // Stimulus
  task automatic run(input logic [7:0] op, input logic poke);
    int n;
    logic [15:0] a;
    for (int i = 1; i <= 7; i++) begin
      a = shadow.stack_pointer + 16'(i);
      if ($isunknown(mem_u.mem[a])) mem_u.mem[a] = 8'($random(seed));
    end
    @(posedge clock);
    #5;
    start = 1'b1;
    opcode = op;
    operand = 8'($random(seed));
    opaddr = 16'($random(seed));
    predict(op, operand);
    seen_rd = 0;
    seen_wr = 0;
    @(posedge clock);
    #5;
    `CHK(busy, 1'b1);
    start = poke;
    if (poke) opcode = 8'h10;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clock);
      #5;
      start = 1'b0;
      n++;
    end
    `CHK(n, cyc);
    @(posedge clock);
    #5;
    `CHK(regs, shadow);
    `CHK({busy, illegal}, 2'b00);
    `CHK(seen_rd, n_rd);
    `CHK(seen_wr, n_wr);
    if (pushed) `CHK(mem_u.mem[push_adr], push_val);
  endtask : run

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) @(posedge clock);
    #5;
    rst_n = 1'b1;
    shadow = '0;
    shadow.stack_pointer = srse_pkg::RST_STACK;
    shadow.flag_register = srse_pkg::RST_FLAGS;
    repeat (2) @(posedge clock);
    #5;
    `CHK(regs, shadow);
  endtask : do_reset

  // Hang guard, generous over some thirteen hundred test cycles
  initial begin
    repeat (12000) @(posedge clock);
    fails++;
    print_verdict();
  end

  initial begin
    seed = 32'h020a0bac;
    rst_n = 1'b0;
    start = 1'b0;
    opcode = 8'h00;
    operand = 8'h00;
    opaddr = 16'h0000;
    do_reset();
    run(8'h3B, 1'b1);
    $display("test start while busy done");
    foreach (OPS[i]) run(OPS[i], 1'b0);
    $display("test opcode sweep done");
    repeat (150) run(OPS[{$random(seed)} % 18], 1'b0);
    $display("test random mix done");
    // Stack pointer at zero so push and pull wrap both ways
    do_reset();
    run(8'h36, 1'b0);
    run(8'h33, 1'b0);
    run(8'h32, 1'b0);
    $display("test stack wrap done");
    print_verdict();
  end
endmodule : stack_rotate_subtract_exec_test
`default_nettype wire
